/* File: bench/sst_exec_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_exec_assertions
	import sst_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic READY,
	input wire logic MEM_RD,
	input wire logic MEM_WR,
	input wire logic PROG_RD,
	input wire logic WORK_WE,
	input wire logic SKIP_NEXT,
	input wire logic DUMMY_CYCLE,
	input wire logic FLAG_WE,
	input wire logic DONE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	chk_no_flags: assert property (!FLAG_WE) else $error("flags");
	chk_skip_stall: assert property (SKIP_NEXT |-> DONE && !READY ##1 READY)
		else $error("stall");
	chk_skip_clean: assert property (SKIP_NEXT |-> !MEM_WR) else $error("skip");
	chk_read_done: assert property (MEM_RD |-> ##2 DONE && READY == !SKIP_NEXT)
		else $error("done");
	chk_mem_kept: assert property (MEM_RD |=> !MEM_WR [*2]) else $error("mem");
	chk_table_write: assert property (PROG_RD |-> ##2 MEM_WR && DONE && READY)
		else $error("table");
	chk_work_only: assert property (WORK_WE |-> DONE && !MEM_WR) else $error("work");
	chk_table_work: assert property (PROG_RD |=> !WORK_WE [*2]) else $error("tw");
	chk_dummy_pair: assert property (DUMMY_CYCLE == SKIP_NEXT) else $error("dummy");
	chk_dummy_quiet: assert property (DUMMY_CYCLE |=> !MEM_RD && !PROG_RD && !WORK_WE && !MEM_WR)
		else $error("quiet");
	cover property (SKIP_NEXT);
	cover property (MEM_WR);
	cover property (WORK_WE);
	cover property (PROG_RD ##2 MEM_WR);
endmodule
bind sst_exec sst_exec_assertions u_chk (.*);
`default_nettype wire

/* File: bench/sst_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_exec_tb
	import sst_pkg::*;
();
	logic CLK_SYS = 0, RESETN = 0, INSTR_VALID = 0;
	sst_op_t INSTR_OP = SST_OP_SWAP_WORK;
	logic [7:0] INSTR_ADDR = 8'h21, TABLE_POINTER = 8'h9e, MEM_RDATA = 8'h00;
	logic [2:0] INSTR_BIT = 3'h0;
	logic [3:0] PC_PAGE = 4'h5;
	logic [14:0] PROG_RDATA = 15'h0000;
	logic READY, MEM_RD, MEM_WR, PROG_RD, WORK_WE, SKIP_NEXT, DUMMY_CYCLE, FLAG_WE, DONE;
	logic [7:0] MEM_ADDR, MEM_WDATA, WORKING_REGISTER;
	logic [11:0] PROG_ADDR;
	logic [6:0] TABLE_HIGH_LATCH;
	int miscompares = 0, total_checks = 0;
	sst_exec #(.PROG_W(15)) DUT (.*);
	always #2.5 CLK_SYS = ~CLK_SYS;
	task automatic ck(string n, logic [14:0] e, g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Take, fetch, then judge the last cycle
	task automatic ex(sst_op_t op, logic [7:0] d, w, logic s);
		@(posedge CLK_SYS);
		#1;
		{INSTR_VALID, INSTR_OP, MEM_RDATA, PROG_RDATA} = {1'b1, op, d, d[6:0], ~d};
		INSTR_ADDR = ~d;
		@(posedge CLK_SYS);
		#1;
		INSTR_VALID = 0;
		repeat (2) @(posedge CLK_SYS);
		#1;
		ck("result", {s, w}, {SKIP_NEXT, WORKING_REGISTER});
		ck("flow", {1'b1, s, ~s}, {DONE, DUMMY_CYCLE, READY});
		ck("maddr", {~d}, MEM_ADDR);
	endtask
	task automatic t_skips();
		ex(SST_OP_SWAP_WORK, 8'h3c, 8'hc3, 0);
		ex(SST_OP_SKIP_ZERO, 8'h00, 8'hc3, 1);
		ex(SST_OP_SKIP_ZERO_MOVE, 8'h00, 8'h00, 1);
		ex(SST_OP_SKIP_ZERO_MOVE, 8'h5a, 8'h5a, 0);
		for (int i = 0; i < 8; i++) begin
			INSTR_BIT = 3'(i);
			ex(SST_OP_SKIP_BIT_CLEAR, ~(8'h01 << i), 8'h5a, 1);
			ex(SST_OP_SKIP_BIT_CLEAR, 8'h01 << i, 8'h5a, 0);
		end
	endtask
	task automatic t_table();
		ex(SST_OP_TABLE_READ, 8'h81, 8'h5a, 0);
		ck("paddr", 12'h59e, PROG_ADDR);
		ck("split", {7'h01, 8'h7e}, {TABLE_HIGH_LATCH, MEM_WDATA});
	endtask
	initial begin
		repeat (20) @(posedge CLK_SYS);
		#1;
		RESETN = 1;
		t_skips();
		t_table();
		final_report();
	end
	initial begin
		#5000;
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire

/* File: hdl/sst_bit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_bit_test
	import sst_pkg::*;
(
	input wire logic [7:0] data,
	input wire logic [2:0] bit_sel,
	output logic bit_clear
);
	logic [7:0] clear_vec;

	genvar g;
	generate
		for (g = 0; g < SST_DATA_W; g++) begin : g_clr
			assign clear_vec[g] = ~data[g];
		end
	endgenerate

	assign bit_clear = clear_vec[bit_sel];
endmodule
`default_nettype wire

/* File: hdl/sst_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_exec
	import sst_pkg::*;
#(
	parameter int PROG_W = 16,
	parameter int PAGE_W = 4,
	parameter int ADDR_W = 8
) (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic INSTR_VALID,
	input wire sst_op_t INSTR_OP,
	input wire logic [ADDR_W-1:0] INSTR_ADDR,
	input wire logic [2:0] INSTR_BIT,
	input wire logic [PAGE_W-1:0] PC_PAGE,
	input wire logic [7:0] TABLE_POINTER,
	input wire logic [7:0] MEM_RDATA,
	input wire logic [PROG_W-1:0] PROG_RDATA,
	output logic READY,
	output logic [ADDR_W-1:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [7:0] MEM_WDATA,
	output logic [PAGE_W+7:0] PROG_ADDR,
	output logic PROG_RD,
	output logic [7:0] WORKING_REGISTER,
	output logic WORK_WE,
	output logic [PROG_W-9:0] TABLE_HIGH_LATCH,
	output logic SKIP_NEXT,
	output logic DUMMY_CYCLE,
	output logic FLAG_WE,
	output logic DONE
);
	typedef struct packed {
		sst_state_t st;
		sst_op_t op;
		logic [2:0] bit_sel;
		logic ready;
		logic [ADDR_W-1:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic [7:0] mem_wdata;
		logic [PAGE_W+7:0] prog_addr;
		logic prog_rd;
		logic [7:0] work;
		logic work_we;
		logic [PROG_W-9:0] tbl_high;
		logic skip;
		logic dummy;
		logic done;
		logic flag_we;
	} sst_regs_t;

	sst_regs_t r;
	sst_regs_t next_r;
	logic [7:0] swapped;
	logic byte_zero;
	logic bit_clear;

	sst_swap u_swap (
		.data(MEM_RDATA),
		.swapped(swapped),
		.zero(byte_zero)
	);

	sst_bit_test u_bit (
		.data(MEM_RDATA),
		.bit_sel(r.bit_sel),
		.bit_clear(bit_clear)
	);

	always_comb begin
		next_r = r;
		// Single-cycle strobes default low
		next_r.mem_rd = 1'b0;
		next_r.mem_wr = 1'b0;
		next_r.prog_rd = 1'b0;
		next_r.work_we = 1'b0;
		next_r.skip = 1'b0;
		next_r.dummy = 1'b0;
		next_r.done = 1'b0;
		// Status flags are never written by this group
		next_r.flag_we = 1'b0;
		unique case (r.st)
			SST_IDLE: begin
				if (INSTR_VALID && r.ready) begin
					next_r.ready = 1'b0;
					next_r.op = INSTR_OP;
					next_r.bit_sel = INSTR_BIT;
					next_r.mem_addr = INSTR_ADDR;
					if (INSTR_OP == SST_OP_TABLE_READ) begin
						next_r.prog_addr = {PC_PAGE, TABLE_POINTER};
						next_r.prog_rd = 1'b1;
						next_r.st = SST_PROG_FETCH;
					end else begin
						next_r.mem_rd = 1'b1;
						next_r.st = SST_MEM_FETCH;
					end
				end
			end
			SST_MEM_FETCH: begin
				next_r.st = SST_MEM_EXEC;
			end
			SST_MEM_EXEC: begin
				next_r.done = 1'b1;
				next_r.st = SST_IDLE;
				next_r.ready = 1'b1;
				unique case (r.op)
					SST_OP_SWAP_WORK: begin
						// Result lands only in the working register; no memory write
						next_r.work = swapped;
						next_r.work_we = 1'b1;
					end
					SST_OP_SKIP_ZERO: begin
						next_r.skip = byte_zero;
					end
					SST_OP_SKIP_ZERO_MOVE: begin
						next_r.work = MEM_RDATA;
						next_r.work_we = 1'b1;
						next_r.skip = byte_zero;
					end
					SST_OP_SKIP_BIT_CLEAR: begin
						next_r.skip = bit_clear;
					end
					default: begin
					end
				endcase
				if (next_r.skip) begin
					next_r.st = SST_DUMMY;
					next_r.ready = 1'b0;
					next_r.dummy = 1'b1;
				end
			end
			SST_PROG_FETCH: begin
				next_r.st = SST_PROG_WRITE;
			end
			SST_PROG_WRITE: begin
				next_r.mem_wr = 1'b1;
				next_r.mem_wdata = PROG_RDATA[7:0];
				next_r.tbl_high = PROG_RDATA[PROG_W-1:8];
				next_r.done = 1'b1;
				next_r.ready = 1'b1;
				next_r.st = SST_IDLE;
			end
			SST_DUMMY: begin
				// Dummy cycle: no strobes, nothing written
				next_r.ready = 1'b1;
				next_r.st = SST_IDLE;
			end
			default: begin
				next_r.st = SST_IDLE;
				next_r.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			r <= '0;
			r.st <= SST_IDLE;
			r.op <= SST_OP_SWAP_WORK;
			r.ready <= 1'b1;
			r.work <= SST_WORK_RESET;
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		READY = r.ready;
		MEM_ADDR = r.mem_addr;
		MEM_RD = r.mem_rd;
		MEM_WR = r.mem_wr;
		MEM_WDATA = r.mem_wdata;
		PROG_ADDR = r.prog_addr;
		PROG_RD = r.prog_rd;
		WORKING_REGISTER = r.work;
		WORK_WE = r.work_we;
		TABLE_HIGH_LATCH = r.tbl_high;
		SKIP_NEXT = r.skip;
		DUMMY_CYCLE = r.dummy;
		FLAG_WE = r.flag_we;
		DONE = r.done;
	end
endmodule
`default_nettype wire

/* File: hdl/sst_pkg.sv */
package sst_pkg;

	typedef enum logic [2:0] {
		SST_OP_SWAP_WORK,
		SST_OP_SKIP_ZERO,
		SST_OP_SKIP_ZERO_MOVE,
		SST_OP_SKIP_BIT_CLEAR,
		SST_OP_TABLE_READ
	} sst_op_t;

	typedef enum logic [2:0] {
		SST_IDLE,
		SST_MEM_FETCH,
		SST_MEM_EXEC,
		SST_PROG_FETCH,
		SST_PROG_WRITE,
		SST_DUMMY
	} sst_state_t;

	localparam int SST_DATA_W = 8;
	localparam int SST_NIB_W = 4;
	localparam int SST_BIT_SEL_W = 3;
	localparam logic [7:0] SST_WORK_RESET = 8'h00;
	localparam int SST_DUMMY_CYCLES = 1;

	function automatic logic sst_is_zero(input logic [7:0] v);
		sst_is_zero = (v == 8'h00);
	endfunction

endpackage

/* File: hdl/sst_swap.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_swap
	import sst_pkg::*;
(
	input wire logic [7:0] data,
	output logic [7:0] swapped,
	output logic zero
);
	always_comb begin
		swapped = {data[SST_NIB_W-1:0], data[SST_DATA_W-1:SST_NIB_W]};
		zero = sst_is_zero(data);
	end
endmodule
`default_nettype wire
